//--- include/crf_pkg.sv
// constants and types shared by the current reference control logic
`default_nettype none

package crf_pkg;

  // special function register addresses
  localparam logic [7:0] CRF_ADDR_CONFIG = 8'hB9;
  localparam logic [7:0] CRF_ADDR_CONTROL = 8'hD6;

  // current_ref_control field layout
  localparam int CRF_CTL_DIR_BIT = 7;
  localparam int CRF_CTL_RANGE_BIT = 6;
  localparam int CRF_CTL_COUNT_MSB = 5;
  localparam int CRF_CTL_COUNT_LSB = 0;
  localparam logic [7:0] CRF_CTL_RESET = 8'h00;
  localparam logic [7:0] CRF_CTL_WMASK = 8'hFF;

  // current_ref_config field layout
  localparam int CRF_CFG_EN_BIT = 7;
  localparam int CRF_CFG_SEL_MSB = 2;
  localparam int CRF_CFG_SEL_LSB = 0;
  localparam logic [7:0] CRF_CFG_RESET = 8'h00;
  localparam logic [7:0] CRF_CFG_WMASK = 8'h87;

  // widths
  localparam int CRF_COUNT_W = 6;
  localparam int CRF_SEL_W = 3;
  localparam int CRF_STEPS_W = 7;
  localparam int CRF_MAG_W = 10;
  localparam int CRF_CUR_W = 11;

  // step sizes in microamps, and weight of the fine unit in steps
  localparam logic [3:0] CRF_STEP_LOW_UA = 4'h1;
  localparam logic [3:0] CRF_STEP_HIGH_UA = 4'h8;
  localparam logic [6:0] CRF_FINE_STEPS = 7'h02;
  localparam logic [5:0] CRF_COUNT_ZERO = 6'h00;

  // fine source select codes; the rest are reserved
  localparam logic [2:0] CRF_SRC_CMP0 = 3'h0;
  localparam logic [2:0] CRF_SRC_CMP1 = 3'h1;
  localparam logic [2:0] CRF_SRC_CMP2 = 3'h2;
  localparam int CRF_NUM_CMP = 3;

  localparam logic [7:0] CRF_RDATA_IDLE = 8'h00;

  // power state of the reference
  typedef enum logic [1:0] {
    CRF_PWR_OFF = 2'b01,
    CRF_PWR_ON = 2'b10
  } crf_pwr_t;

endpackage

`default_nettype wire

//--- logic/crf_fine_gate.sv
// picks one compare output and gates the extra fine current unit
`timescale 1ns/100ps
`default_nettype none

module crf_fine_gate
  import crf_pkg::*;
#(
  parameter int NUM_CMP = CRF_NUM_CMP
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic [CRF_SEL_W-1:0] source_select,
  input wire logic [NUM_CMP-1:0] compare_output,
  output logic fine_unit_on,
  output logic source_valid
);

  typedef struct packed {
    logic on;
    logic valid;
  } crf_fine_state_t;

  crf_fine_state_t state_reg;
  crf_fine_state_t state_next;
  logic [NUM_CMP-1:0] hit;

  // one match term per compare output
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi = gi + 1) begin : g_hit
      assign hit[gi] = (source_select == CRF_SEL_W'(gi)) && compare_output[gi];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    // codes beyond the last channel are reserved
    state_next.valid = (source_select < CRF_SEL_W'(NUM_CMP));
    // reserved code or mode off keeps unit dark
    state_next.on = enable && state_next.valid && (|hit);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fine_unit_on = state_reg.on;
  assign source_valid = state_reg.valid;

endmodule // crf_fine_gate

`default_nettype wire

//--- logic/crf_current_ref.sv
// register file and output control of the programmable current reference
`timescale 1ns/100ps
`default_nettype none

module crf_current_ref
  import crf_pkg::*;
#(
  parameter int NUM_CMP = CRF_NUM_CMP
) (
  input wire logic clk_sys,
  input wire logic rst,
  // special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // counter array compare outputs, same clock
  input wire logic [NUM_CMP-1:0] compare_output,
  // to the analog output stage
  output logic ref_enable,
  output logic sink_select,
  output logic range_select,
  output logic [CRF_COUNT_W-1:0] step_count,
  output logic fine_unit_on,
  output logic enhanced_mode_enable,
  output logic fine_source_valid,
  output logic [CRF_MAG_W-1:0] current_magnitude_ua,
  output logic signed [CRF_CUR_W-1:0] current_signed_ua
);

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] config_r;
    crf_pwr_t pwr;
    logic [7:0] rdata;
    logic rvalid;
    logic [CRF_MAG_W-1:0] mag;
    logic signed [CRF_CUR_W-1:0] cur;
  } crf_state_t;

  crf_state_t state_reg;
  crf_state_t state_next;

  logic hit_control;
  logic hit_config;
  logic [CRF_COUNT_W-1:0] count_now;
  logic dir_now;
  logic range_now;
  logic mode_now;
  logic [CRF_SEL_W-1:0] sel_now;
  logic fine_on;
  logic fine_valid;
  logic [CRF_STEPS_W-1:0] steps_total;
  logic [CRF_MAG_W-1:0] mag_calc;
  logic [7:0] read_mux;

  assign hit_control = (sfr_addr == CRF_ADDR_CONTROL);
  assign hit_config = (sfr_addr == CRF_ADDR_CONFIG);

  // fields as currently stored
  assign dir_now = state_reg.control[CRF_CTL_DIR_BIT];
  assign range_now = state_reg.control[CRF_CTL_RANGE_BIT];
  assign count_now = state_reg.control[CRF_CTL_COUNT_MSB:CRF_CTL_COUNT_LSB];
  assign mode_now = state_reg.config_r[CRF_CFG_EN_BIT];
  assign sel_now = state_reg.config_r[CRF_CFG_SEL_MSB:CRF_CFG_SEL_LSB];

  // fine unit only while the reference itself is on
  crf_fine_gate #(
    .NUM_CMP(NUM_CMP)
  ) u_fine_gate (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(mode_now && (state_reg.pwr == CRF_PWR_ON)),
    .source_select(sel_now),
    .compare_output(compare_output),
    .fine_unit_on(fine_on),
    .source_valid(fine_valid)
  );

  // fine unit worth binary 10 in the count
  always_comb begin
    steps_total = {1'b0, count_now};
    if (fine_on) begin
      steps_total = 7'(steps_total + CRF_FINE_STEPS);
    end
  end

  // step size from the range bit
  // magnitude as steps times step size
  always_comb begin
    if (range_now) begin
      mag_calc = CRF_MAG_W'(steps_total) * CRF_MAG_W'(CRF_STEP_HIGH_UA);
    end else begin
      mag_calc = CRF_MAG_W'(steps_total) * CRF_MAG_W'(CRF_STEP_LOW_UA);
    end
  end

  // unused config bits read back as zero
  always_comb begin
    if (hit_control) begin
      read_mux = state_reg.control;
    end else if (hit_config) begin
      read_mux = state_reg.config_r & CRF_CFG_WMASK;
    end else begin
      read_mux = CRF_RDATA_IDLE;
    end
  end

  always_comb begin
    state_next = state_reg;

    // register writes; a write lands at the end of its cycle
    if (sfr_wr && hit_control) begin
      state_next.control = sfr_wdata & CRF_CTL_WMASK;
    end
    // bit 7 stored as the mode switch
    if (sfr_wr && hit_config) begin
      state_next.config_r = sfr_wdata & CRF_CFG_WMASK;
    end

    // reads answer one cycle later with the value before any same-cycle write
    state_next.rvalid = sfr_rd;
    if (sfr_rd) begin
      state_next.rdata = read_mux;
    end else begin
      state_next.rdata = CRF_RDATA_IDLE;
    end

    // zero count drops to low power
    case (state_reg.pwr)
      CRF_PWR_OFF: begin
        if (count_now != CRF_COUNT_ZERO) begin
          state_next.pwr = CRF_PWR_ON;
        end
      end
      CRF_PWR_ON: begin
        if (count_now == CRF_COUNT_ZERO) begin
          state_next.pwr = CRF_PWR_OFF;
        end
      end
      default: begin
        state_next.pwr = CRF_PWR_OFF;
      end
    endcase

    if (state_reg.pwr == CRF_PWR_ON) begin
      state_next.mag = mag_calc;
    end else begin
      state_next.mag = '0;
    end

    if (dir_now) begin
      state_next.cur = -$signed({1'b0, state_next.mag});
    end else begin
      state_next.cur = $signed({1'b0, state_next.mag});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg.control <= CRF_CTL_RESET;
      state_reg.config_r <= CRF_CFG_RESET;
      state_reg.pwr <= CRF_PWR_OFF;
      state_reg.rdata <= CRF_RDATA_IDLE;
      state_reg.rvalid <= 1'b0;
      state_reg.mag <= '0;
      state_reg.cur <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = state_reg.rdata;
  assign sfr_rvalid = state_reg.rvalid;
  assign ref_enable = (state_reg.pwr == CRF_PWR_ON);
  assign sink_select = dir_now;
  assign range_select = range_now;
  assign step_count = count_now;
  assign fine_unit_on = fine_on;
  assign enhanced_mode_enable = mode_now;
  assign fine_source_valid = fine_valid;
  assign current_magnitude_ua = state_reg.mag;
  assign current_signed_ua = state_reg.cur;

endmodule // crf_current_ref

`default_nettype wire

//--- tb/crf_current_ref_props.sv
// assertions on the ports of the current reference control block
`timescale 1ns/100ps
`default_nettype none
module crf_current_ref_props
  import crf_pkg::*;
#(
  parameter int NUM_CMP = CRF_NUM_CMP
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic [NUM_CMP-1:0] compare_output,
  input wire logic ref_enable,
  input wire logic sink_select,
  input wire logic range_select,
  input wire logic [CRF_COUNT_W-1:0] step_count,
  input wire logic fine_unit_on,
  input wire logic enhanced_mode_enable,
  input wire logic fine_source_valid,
  input wire logic [CRF_MAG_W-1:0] current_magnitude_ua
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_WR_CTL: assert property (
    sfr_wr && sfr_addr == 8'hD6 |=> {sink_select, range_select, step_count} == $past(sfr_wdata))
    else $error("control write not applied");
  // a reset edge clears the count with no one-cycle lag, so skip the edge after it
  AST_EN: assert property (
    !$past(rst) |-> ref_enable == ($past(step_count) != 6'h00))
    else $error("enable does not follow count");
  AST_MAG_OFF: assert property (
    !$past(ref_enable) |-> current_magnitude_ua == 10'h000) else $error("current while off");
  AST_MAG: assert property (
    !$past(rst) && $past(ref_enable) |-> current_magnitude_ua
      == ($past(range_select) ? 10'h008 : 10'h001)
      * (10'($past(step_count)) + ($past(fine_unit_on) ? 10'h002 : 10'h000)))
    else $error("current magnitude not step times count");
  AST_FINE_GATE: assert property (
    fine_unit_on |-> fine_source_valid && $past(ref_enable) && $past(enhanced_mode_enable)
      && $past(|compare_output))
    else $error("fine unit on without cause");
  AST_CFG_WR: assert property (
    sfr_wr && sfr_addr == 8'hB9 |=> enhanced_mode_enable == $past(sfr_wdata[7]))
    else $error("mode bit not applied");
  AST_RD_CFG: assert property (
    sfr_rd && sfr_addr == 8'hB9 |=> sfr_rvalid && sfr_rdata[6:3] == 4'h0)
    else $error("config unused bits not zero");
  AST_RD_CTL: assert property (
    sfr_rd && !sfr_wr && sfr_addr == 8'hD6 |=> sfr_rvalid
      && sfr_rdata == {$past(sink_select), $past(range_select), $past(step_count)})
    else $error("control read mismatch");
  AST_RD_IDLE: assert property (
    !sfr_rvalid |-> sfr_rdata == 8'h00) else $error("read data not idle");
  AST_RST: assert property (
    $fell(rst) |-> step_count == 6'h00 && !enhanced_mode_enable && !ref_enable)
    else $error("state not cleared by reset");
  cover property (sfr_wr && sfr_addr == 8'hD6);
  cover property (fine_unit_on);
  cover property (sfr_rd && sfr_addr == 8'hB9);
endmodule // crf_current_ref_props
bind crf_current_ref crf_current_ref_props #(.NUM_CMP(NUM_CMP)) props (
  .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
  .compare_output(compare_output), .ref_enable(ref_enable), .sink_select(sink_select),
  .range_select(range_select), .step_count(step_count), .fine_unit_on(fine_unit_on),
  .enhanced_mode_enable(enhanced_mode_enable), .fine_source_valid(fine_source_valid),
  .current_magnitude_ua(current_magnitude_ua)
);
`default_nettype wire

//--- tb/crf_stage_model.sv
// behavioural analog output stage, current in microamps
`timescale 1ns/100ps
`default_nettype none
module crf_stage_model (
  input wire logic ref_enable,
  input wire logic sink_select,
  input wire logic range_select,
  input wire logic [5:0] step_count,
  input wire logic fine_unit_on,
  output int ua
);
  always_comb begin
    ua = ref_enable ? (range_select ? 8 : 1) * (int'(step_count) + (fine_unit_on ? 2 : 0)) : 0;
    if (sink_select) begin
      ua = -ua;
    end
  end
endmodule // crf_stage_model
`default_nettype wire

//--- tb/crf_current_ref_tb.sv
// self-checking bench for the current reference control block
`timescale 1ns/100ps
`default_nettype none
module crf_current_ref_tb;
  import crf_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0] compare_output = 3'h0;
  logic sfr_rvalid, ref_enable, sink_select, range_select, fine_unit_on;
  logic enhanced_mode_enable, fine_source_valid;
  logic [5:0] step_count;
  logic [9:0] current_magnitude_ua;
  logic signed [10:0] current_signed_ua;
  int ua, mismatches = 0, checked = 0;
  logic [7:0] ctl [6] = '{8'h45, 8'hBF, 8'hFF, 8'h7F, 8'h01, 8'h00};
  int exp_ua [6] = '{40, -63, -504, 504, 1, 0};
  always #10 clk_sys = ~clk_sys;
  crf_current_ref dut (
    .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .compare_output(compare_output), .ref_enable(ref_enable), .sink_select(sink_select),
    .range_select(range_select), .step_count(step_count), .fine_unit_on(fine_unit_on),
    .enhanced_mode_enable(enhanced_mode_enable), .fine_source_valid(fine_source_valid),
    .current_magnitude_ua(current_magnitude_ua), .current_signed_ua(current_signed_ua)
  );
  crf_stage_model stage (
    .ref_enable(ref_enable), .sink_select(sink_select), .range_select(range_select),
    .step_count(step_count), .fine_unit_on(fine_unit_on), .ua(ua)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // settle time covers the two-cycle lag to the current outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk({7'h00, sfr_rvalid, sfr_rdata}, {8'h01, exp});
  endtask
  task automatic cur_is(input int e);
    chk(16'(current_signed_ua), 16'(e));
    chk(16'(current_magnitude_ua), 16'(e < 0 ? -e : e));
    chk(16'(ua), 16'(e));
  endtask
  task automatic fine(input logic [2:0] c, input int e);
    @(negedge clk_sys);
    compare_output = c;
    repeat (3) @(negedge clk_sys);
    cur_is(e);
  endtask
  task automatic summarize();
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    rd(CRF_ADDR_CONTROL, 8'h00);
    rd(CRF_ADDR_CONFIG, 8'h00);
    cur_is(0);
    foreach (ctl[i]) begin
      wr(CRF_ADDR_CONTROL, ctl[i]);
      cur_is(exp_ua[i]);
      chk(16'(ref_enable), 16'(exp_ua[i] != 0));
      rd(CRF_ADDR_CONTROL, ctl[i]);
    end
    wr(CRF_ADDR_CONTROL, 8'h04);
    wr(CRF_ADDR_CONFIG, 8'hFF);
    rd(CRF_ADDR_CONFIG, 8'h87);
    chk(16'(fine_source_valid), 16'h0000);
    fine(3'h7, 4);
    for (int s = 0; s < 3; s++) begin
      wr(CRF_ADDR_CONFIG, 8'h80 | 8'(s));
      chk(16'(fine_source_valid), 16'h0001);
      fine(3'(1 << s), 6);
      fine(~3'(1 << s), 4);
    end
    wr(CRF_ADDR_CONTROL, 8'hC4);
    fine(3'h4, -48);
    wr(CRF_ADDR_CONTROL, 8'h06);
    fine(3'h0, 6);
    wr(CRF_ADDR_CONFIG, 8'h02);
    fine(3'h7, 6);
    chk(16'(fine_unit_on), 16'h0000);
    wr(CRF_ADDR_CONFIG, 8'h82);
    wr(CRF_ADDR_CONTROL, 8'h00);
    fine(3'h7, 0);
    // unmapped place must neither store nor disturb
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    rd(CRF_ADDR_CONTROL, 8'h00);
    wr(CRF_ADDR_CONTROL, 8'h3F);
    chk(16'(ref_enable), 16'h0001);
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    rd(CRF_ADDR_CONTROL, 8'h00);
    rd(CRF_ADDR_CONFIG, 8'h00);
    cur_is(0);
    chk(16'(ref_enable), 16'h0000);
    summarize();
  end
endmodule // crf_current_ref_tb
`default_nettype wire
